//--- hw/scx_serial.sv
// Serial character transmitter and receiver
`timescale 1ns/1ps
`default_nettype none
`include "scx_cfg.svh"
module scx_serial
  import scx_pkg::*;
#(
  parameter int RT_DIV     = `SCX_RT_DIV,
  parameter int FIFO_DEPTH = `SCX_FIFO_DEPTH
) (
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  input  wire logic       serial_unit_enable_in,
  input  wire logic       tx_enable_in,
  input  wire logic       nine_bit_select_in,
  input  wire logic       tx_invert_in,
  input  wire logic       send_break_in,
  input  wire logic       break_len_ext_in,
  input  wire logic       tx_ninth_bit_in,
  input  wire logic       tx_empty_irq_en_in,
  input  wire logic       tx_done_irq_en_in,
  input  wire logic       rx_full_irq_en_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_data_valid_in,
  output var  logic       tx_data_ready_out,
  input  wire logic       stat_one_read_in,
  input  wire logic       data_read_in,
  input  wire logic       rxd_in,
  output var  logic       txd_out,
  output var  logic       txd_oe_n_out,
  output var  logic       pins_owned_out,
  output var  logic [7:0] rx_data_out,
  output var  logic       rx_ninth_bit_out,
  output var  logic       tx_empty_flag_out,
  output var  logic       tx_done_flag_out,
  output var  logic       rx_full_flag_out,
  output var  logic       framing_flag_out,
  output var  logic       noise_flag_out,
  output var  logic       overrun_flag_out,
  output var  logic       break_flag_out,
  output var  logic       rx_active_flag_out,
  output var  logic       tx_irq_out,
  output var  logic       rx_irq_out
);
  // ------------------------------------------------------------
  // Tick, FIFO and data buffer
  // ------------------------------------------------------------
  logic             rt_tick;
  logic             en;
  logic [8:0]       fifo_data;
  logic             fifo_valid;
  logic [8:0]       buf_reg;
  logic             buf_full_reg;
  logic             fifo_ready_out;
  scx_tx_state_type tx_state_reg;
  logic [11:0]      tx_shift_reg;
  logic [3:0]       tx_left_reg;
  logic [3:0]       tx_rt_reg;
  logic             tx_bit_tick;
  logic             tx_last;
  logic             preamble_done_reg;
  logic             te_prev_reg;
  logic             te_dropped_reg;
  logic             idle_queued_reg;
  logic             load_data;

  assign en = serial_unit_enable_in;

  scx_rt_tick #(.DIV(RT_DIV)) u_tick (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .run_in   (en),
    .tick_out (rt_tick)
  );

  // Data written by software is queued ahead of the data buffer
  scx_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk_in      (mclk_in),
    .reset_in     (reset_in),
    .wr_data_in   ({tx_ninth_bit_in, tx_data_in}),
    .wr_valid_in  (tx_data_valid_in),
    .wr_ready_out (fifo_ready_out),
    .rd_data_out  (fifo_data),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (!buf_full_reg)
  );
  assign tx_data_ready_out = fifo_ready_out;

  // Write-side data buffer feeding the shifter
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      buf_full_reg <= 1'b0;
      buf_reg      <= 9'h000;
    end else if (load_data) begin
      buf_full_reg <= 1'b0;
    end else if (!buf_full_reg && fifo_valid) begin
      buf_full_reg <= 1'b1;
      buf_reg      <= fifo_data;
    end
  end

  // ------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------
  assign tx_bit_tick = rt_tick && (tx_rt_reg == `SCX_RT_LAST);
  assign tx_last     = (tx_state_reg == SCX_TX_IDLE) || (tx_left_reg == 4'h1);
  assign load_data   = tx_bit_tick && tx_last && !send_break_in && tx_state_reg != SCX_TX_BREAK
                       && !idle_queued_reg && tx_enable_in && buf_full_reg && preamble_done_reg;

  // Bit timing of the transmitter
  always_ff @(posedge mclk_in) begin
    if (reset_in || !en) begin
      tx_rt_reg <= 4'h0;
    end else if (rt_tick) begin
      tx_rt_reg <= tx_rt_reg + 4'h1;
    end
  end

  // Enable edge tracking for queued idle
  always_ff @(posedge mclk_in) begin
    if (reset_in || !en) begin
      te_prev_reg     <= 1'b0;
      te_dropped_reg  <= 1'b0;
      idle_queued_reg <= 1'b0;
    end else begin
      te_prev_reg <= tx_enable_in;
      if (tx_state_reg == SCX_TX_IDLE) begin
        te_dropped_reg <= 1'b0;
      end else if (te_prev_reg && !tx_enable_in) begin
        te_dropped_reg <= 1'b1;
      end
      if (tx_state_reg == SCX_TX_IDLECH) begin
        idle_queued_reg <= 1'b0;
      end else if (te_dropped_reg && !te_prev_reg && tx_enable_in) begin
        idle_queued_reg <= 1'b1;
      end
    end
  end

  // Character sequencer: break, mark, queued idle, preamble, data
  always_ff @(posedge mclk_in) begin
    if (reset_in || !en) begin
      tx_state_reg      <= SCX_TX_IDLE;
      tx_shift_reg      <= 12'hFFF;
      tx_left_reg       <= 4'h0;
      preamble_done_reg <= 1'b0;
    end else begin
      if (!tx_enable_in) preamble_done_reg <= 1'b0;
      if (tx_bit_tick && !tx_last) begin
        tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
        tx_left_reg  <= tx_left_reg - 4'h1;
      end else if (tx_bit_tick) begin
        if (send_break_in) begin
          tx_state_reg <= SCX_TX_BREAK;
          tx_shift_reg <= 12'h000;
          tx_left_reg  <= `SCX_BITS_8 + 4'(nine_bit_select_in) + 4'(break_len_ext_in);
        end else if (tx_state_reg == SCX_TX_BREAK) begin
          tx_state_reg <= SCX_TX_MARK;
          tx_shift_reg <= 12'hFFF;
          tx_left_reg  <= 4'h1;
        end else if (idle_queued_reg) begin
          tx_state_reg      <= SCX_TX_IDLECH;
          tx_shift_reg      <= 12'hFFF;
          tx_left_reg       <= `SCX_BITS_8 + 4'(nine_bit_select_in);
          preamble_done_reg <= 1'b1; // Queued idle stands in for the preamble
        end else if (tx_enable_in && buf_full_reg && !preamble_done_reg) begin
          tx_state_reg      <= SCX_TX_PREAMBLE;
          tx_shift_reg      <= 12'hFFF;
          tx_left_reg       <= `SCX_BITS_8 + 4'(nine_bit_select_in);
          preamble_done_reg <= 1'b1;
        end else if (load_data) begin
          tx_state_reg <= SCX_TX_DATA;
          tx_shift_reg <= nine_bit_select_in ? {2'b11, buf_reg, 1'b0} : {3'b111, buf_reg[7:0], 1'b0};
          tx_left_reg  <= `SCX_BITS_8 + 4'(nine_bit_select_in);
        end else begin
          tx_state_reg <= SCX_TX_IDLE;
          tx_shift_reg <= 12'hFFF;
          tx_left_reg  <= 4'h0;
        end
      end
    end
  end

  // Pin drive, inversion and release
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      txd_out        <= 1'b1;
      txd_oe_n_out   <= 1'b1;
      pins_owned_out <= 1'b0;
    end else begin
      txd_out        <= tx_shift_reg[0] ^ tx_invert_in;
      txd_oe_n_out   <= !(en && tx_enable_in || en && tx_state_reg != SCX_TX_IDLE);
      pins_owned_out <= en;
    end
  end

  // Transmit flags and request
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      tx_empty_flag_out <= 1'b1;
      tx_done_flag_out  <= 1'b1;
      tx_irq_out        <= 1'b0;
    end else begin
      tx_empty_flag_out <= !buf_full_reg;
      tx_done_flag_out  <= !buf_full_reg && !fifo_valid && tx_state_reg == SCX_TX_IDLE;
      tx_irq_out        <= (!buf_full_reg && tx_empty_irq_en_in)
                           || (tx_done_flag_out && tx_done_irq_en_in);
    end
  end

  // ------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------
  logic             rx_s1_reg;
  logic             rx_s2_reg;
  logic [2:0]       hist_reg;
  scx_rx_state_type rx_state_reg;
  logic [3:0]       rx_rt_reg;
  logic [3:0]       rx_idx_reg;
  logic [1:0]       smp_reg;
  logic [9:0]       rx_shift_reg;
  logic             all_zero_reg;
  logic             ext_reg;
  logic             noise_acc_reg;
  logic             maj;
  logic             disagree;
  logic             stop_pos;
  logic             done;
  logic             is_break;
  logic             armed_reg;

  assign maj      = (smp_reg[1] & smp_reg[0]) | (smp_reg[1] & rx_s2_reg) | (smp_reg[0] & rx_s2_reg);
  assign disagree = !((smp_reg == 2'b11 && rx_s2_reg) || (smp_reg == 2'b00 && !rx_s2_reg));
  assign stop_pos = (rx_idx_reg == (`SCX_BITS_8 - 4'h1 + 4'(nine_bit_select_in) + 4'(ext_reg)));
  assign done     = rt_tick && rx_state_reg == SCX_RX_BITS && rx_rt_reg == `SCX_RT_SAMPLE && stop_pos
                    && !(break_len_ext_in && !ext_reg && all_zero_reg && !maj);
  assign is_break = all_zero_reg && !maj;

  // Two-stage input synchroniser
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
    end else begin
      rx_s1_reg <= rxd_in;
      rx_s2_reg <= rx_s1_reg;
    end
  end

  // Start search, verification and bit sampling at 16x
  always_ff @(posedge mclk_in) begin
    if (reset_in || !en) begin
      rx_state_reg  <= SCX_RX_HUNT;
      hist_reg      <= 3'b000;
      rx_rt_reg     <= 4'h0;
      rx_idx_reg    <= 4'h0;
      smp_reg       <= 2'b00;
      rx_shift_reg  <= 10'h000;
      all_zero_reg  <= 1'b1;
      ext_reg       <= 1'b0;
      noise_acc_reg <= 1'b0;
    end else if (rt_tick) begin
      hist_reg  <= {hist_reg[1:0], rx_s2_reg};
      rx_rt_reg <= rx_rt_reg + 4'h1;
      case (rx_state_reg)
        SCX_RX_HUNT: begin
          if (hist_reg == 3'b111 && !rx_s2_reg) begin
            rx_state_reg  <= SCX_RX_START;
            rx_rt_reg     <= 4'h2;
            rx_idx_reg    <= 4'h0;
            all_zero_reg  <= 1'b1;
            ext_reg       <= 1'b0;
            noise_acc_reg <= 1'b0;
          end
        end
        SCX_RX_START: begin
          if (rx_rt_reg == 4'h3 || rx_rt_reg == 4'h5) smp_reg <= {smp_reg[0], rx_s2_reg};
          if (rx_rt_reg == `SCX_RT_VERIFY) begin
            if (maj) begin
              rx_state_reg <= SCX_RX_HUNT;
            end else begin
              rx_state_reg  <= SCX_RX_BITS;
              noise_acc_reg <= disagree;
            end
          end
        end
        SCX_RX_BITS: begin
          if (rx_rt_reg == 4'h8 || rx_rt_reg == 4'h9) smp_reg <= {smp_reg[0], rx_s2_reg};
          if (rx_rt_reg == `SCX_RT_SAMPLE) begin
            noise_acc_reg <= noise_acc_reg | disagree;
            if (rx_idx_reg != 4'h0 && !stop_pos) begin // Stop positions stay out of the data
              rx_shift_reg <= {maj, rx_shift_reg[9:1]};
              if (maj) all_zero_reg <= 1'b0;
            end
            if (done) begin
              rx_state_reg <= SCX_RX_HUNT;
            end else if (stop_pos) begin
              ext_reg <= 1'b1;
            end
          end
          if (rx_rt_reg == `SCX_RT_LAST) rx_idx_reg <= rx_idx_reg + 4'h1;
        end
        default: rx_state_reg <= SCX_RX_HUNT;
      endcase
    end
  end

  // Read buffer, flags and their clearing sequence
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rx_data_out        <= 8'h00;
      rx_ninth_bit_out   <= 1'b0;
      rx_full_flag_out   <= 1'b0;
      framing_flag_out   <= 1'b0;
      noise_flag_out     <= 1'b0;
      overrun_flag_out   <= 1'b0;
      break_flag_out     <= 1'b0;
      armed_reg          <= 1'b0;
      rx_active_flag_out <= 1'b0;
      rx_irq_out         <= 1'b0;
    end else begin
      rx_active_flag_out <= (rx_state_reg != SCX_RX_HUNT);
      rx_irq_out         <= rx_full_flag_out && rx_full_irq_en_in;
      if (stat_one_read_in && rx_full_flag_out) armed_reg <= 1'b1;
      if (done) begin
        rx_full_flag_out <= 1'b1;
        framing_flag_out <= !maj || ext_reg;
        noise_flag_out   <= noise_acc_reg | disagree;
        overrun_flag_out <= rx_full_flag_out;
        break_flag_out   <= is_break;
        armed_reg        <= 1'b0;
        if (!rx_full_flag_out) begin
          if (is_break) begin
            rx_data_out      <= 8'h00;
            rx_ninth_bit_out <= 1'b0;
          end else if (nine_bit_select_in) begin
            rx_data_out      <= rx_shift_reg[8:1];
            rx_ninth_bit_out <= rx_shift_reg[9];
          end else begin
            rx_data_out      <= rx_shift_reg[9:2];
            rx_ninth_bit_out <= rx_shift_reg[9];
          end
        end
      end else if (data_read_in && armed_reg) begin
        rx_full_flag_out <= 1'b0;
        framing_flag_out <= 1'b0;
        noise_flag_out   <= 1'b0;
        overrun_flag_out <= 1'b0;
        break_flag_out   <= 1'b0;
        armed_reg        <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_idle_level;
    @(posedge mclk_in) disable iff (reset_in)
    $past(tx_state_reg == SCX_TX_IDLE && en) |-> txd_out == !$past(tx_invert_in);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle level wrong");

  property p_break_zero;
    @(posedge mclk_in) disable iff (reset_in)
    (tx_state_reg == SCX_TX_BREAK && !tx_invert_in) ##1 (!tx_invert_in) |-> !txd_out;
  endproperty
  a_break_zero: assert property (p_break_zero) else $error("break not low");

  property p_mark_after_break;
    @(posedge mclk_in) disable iff (reset_in || !en)
    (tx_state_reg == SCX_TX_BREAK) ##1 (tx_state_reg != SCX_TX_BREAK) |-> tx_state_reg == SCX_TX_MARK;
  endproperty
  a_mark_after_break: assert property (p_mark_after_break) else $error("no mark after break");

  property p_preamble_first;
    @(posedge mclk_in) disable iff (reset_in || !en)
    $rose(tx_state_reg == SCX_TX_DATA) |-> $past(preamble_done_reg);
  endproperty
  a_preamble_first: assert property (p_preamble_first) else $error("data without preamble");

  property p_start_bit;
    @(posedge mclk_in) disable iff (reset_in || !en)
    $rose(tx_state_reg == SCX_TX_DATA) |-> !tx_shift_reg[0];
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit not zero");

  property p_empty_on_load;
    @(posedge mclk_in) disable iff (reset_in)
    load_data |-> ##2 tx_empty_flag_out;
  endproperty
  a_empty_on_load: assert property (p_empty_on_load) else $error("empty flag late");

  property p_release;
    @(posedge mclk_in) disable iff (reset_in)
    !en ##1 !en |-> txd_oe_n_out && !pins_owned_out;
  endproperty
  a_release: assert property (p_release) else $error("pins not released");

  property p_fe_with_full;
    @(posedge mclk_in) disable iff (reset_in)
    $rose(framing_flag_out) |-> $rose(rx_full_flag_out) || $past(rx_full_flag_out);
  endproperty
  a_fe_with_full: assert property (p_fe_with_full) else $error("framing without full");

  property p_break_clears;
    @(posedge mclk_in) disable iff (reset_in)
    $rose(break_flag_out) && !$past(rx_full_flag_out) |-> rx_data_out == 8'h00 && framing_flag_out;
  endproperty
  a_break_clears: assert property (p_break_clears) else $error("break effects missing");

  property p_done_idle;
    @(posedge mclk_in) disable iff (reset_in)
    tx_done_flag_out |-> $past(tx_state_reg == SCX_TX_IDLE && !buf_full_reg);
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("done while busy");

  c_data_sent:  cover property (@(posedge mclk_in) disable iff (reset_in) load_data);
  c_break_rx:   cover property (@(posedge mclk_in) disable iff (reset_in) $rose(break_flag_out));
  c_rx_char:    cover property (@(posedge mclk_in) disable iff (reset_in) done && !is_break);
  c_idle_queue: cover property (@(posedge mclk_in) disable iff (reset_in) tx_state_reg == SCX_TX_IDLECH);
endmodule : scx_serial
`default_nettype wire

//--- common/scx_cfg.svh
// Constants of the serial character transmitter and receiver
// Function
// - Transmitter sends 8 or 9 bit characters; ninth bit comes from tx_ninth_bit.
// - A transmission starts with an all-ones preamble, then the buffered word loads.
// - Each frame has a 0 start bit first and a 1 stop bit last.
// - tx_empty_flag sets when buffer hands over; interrupt when enabled.
// - Output rests at logic 1, before inversion, when nothing is shifted.
// - Clearing serial_unit_enable releases both pins to port control.
// - send_break loads an all-zero break, length by nine_bit_select and break_len_ext.
// - Breaks repeat while send_break holds; afterwards at least one 1 bit follows.
// - Without break_len_ext a break is 10 or 11 consecutive zeros.
// - With break_len_ext a break is 11 or 12 consecutive zeros.
// - A break sets framing, full and break flags and clears data and ninth bit.
// - An idle character is all ones, length by nine_bit_select; preamble is one.
// - Dropping tx_enable finishes the current character, then idles the output.
// - Dropping and raising tx_enable mid-character queues one idle character.
// - tx_invert inverts every transmitted level, idle, break, start and stop.
// - tx_done_flag sets when shifter and buffer are empty and nothing generated.
// - Receiver takes 8 or 9 bits; rx_ninth_bit is bit 8, or bit 7.
// - A complete character moves to the read buffer and sets rx_full_flag.
// - One data address: write buffer to transmitter, read buffer from receiver.
// - Receiver samples its input at sixteen times the baud rate.
// - Bit value is majority of ticks 8, 9, 10; disagreement sets noise_flag.
// - framing_flag sets with rx_full_flag when the stop position holds no 1.
`ifndef SCX_CFG_SVH
`define SCX_CFG_SVH
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SCX_CLK_HZ      125000000
`define SCX_BAUD_HZ     9600
`define SCX_RT_PER_BIT  16
`define SCX_RT_DIV      (`SCX_CLK_HZ / (`SCX_BAUD_HZ * `SCX_RT_PER_BIT))
`define SCX_FIFO_DEPTH  16
// ------------------------------------------------------------
// Frame layout
// ------------------------------------------------------------
`define SCX_BITS_8      4'h0A
`define SCX_RT_VERIFY   4'h7
`define SCX_RT_SAMPLE   4'hA
`define SCX_RT_LAST     4'hF
`endif

//--- common/scx_pkg.sv
// Types of the serial character transmitter and receiver
`default_nettype none
package scx_pkg;
  typedef enum logic [2:0] {
    SCX_TX_IDLE, SCX_TX_PREAMBLE, SCX_TX_DATA, SCX_TX_BREAK, SCX_TX_MARK, SCX_TX_IDLECH
  } scx_tx_state_type;
  typedef enum logic [1:0] {
    SCX_RX_HUNT, SCX_RX_START, SCX_RX_BITS
  } scx_rx_state_type;
endpackage : scx_pkg
`default_nettype wire

//--- hw/scx_rt_tick.sv
// Sixteen-times-baud tick divider
`timescale 1ns/1ps
`default_nettype none
module scx_rt_tick
  import scx_pkg::*;
#(
  parameter int DIV = 813
) (
  input  wire logic mclk_in,
  input  wire logic reset_in,
  input  wire logic run_in,
  output var  logic tick_out
);
  logic [15:0] cnt_reg;

  // Free divider, held while the unit is off
  always_ff @(posedge mclk_in) begin
    if (reset_in || !run_in) begin
      cnt_reg  <= 16'h0000;
      tick_out <= 1'b0;
    end else if (cnt_reg == 16'(DIV - 1)) begin
      cnt_reg  <= 16'h0000;
      tick_out <= 1'b1;
    end else begin
      cnt_reg  <= cnt_reg + 16'h0001;
      tick_out <= 1'b0;
    end
  end
endmodule : scx_rt_tick
`default_nettype wire

//--- hw/scx_fifo.sv
// Transmit data FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module scx_fifo
  import scx_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output var  logic             wr_ready_out,
  output var  logic [WIDTH-1:0] rd_data_out,
  output var  logic             rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;
  logic [AW:0]      count_next;

  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;
  assign count_next   = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign rd_valid_out = (count_reg != '0);
  assign rd_data_out  = mem_reg[rd_ptr_reg];

  // Storage
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= wr_data_in;
    end
  end

  // Pointers, fill level and registered ready from the next level
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      count_reg    <= '0;
      wr_ready_out <= 1'b1;
    end else begin
      if (push) wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      count_reg    <= count_next;
      wr_ready_out <= (count_next != (AW+1)'(DEPTH));
    end
  end
endmodule : scx_fifo
`default_nettype wire

//--- tb/scx_remote.sv
// Remote serial device model: sends frames and captures frames
`timescale 1ns/1ps
`default_nettype none
module scx_remote #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic mclk_in,
  input  wire logic line_in,
  output var  logic line_out
);
  // Line rests at mark level between frames
  initial line_out = 1'b1;
  // Send n bits LSB first, start bit included
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      line_out <= bits[i];
      repeat (BIT_CLKS) @(posedge mclk_in);
    end
    line_out <= 1'b1;
  endtask : send
  // Capture n bits at mid bit from the first falling edge
  task automatic catch(output logic [10:0] bits, input int n);
    bits = '1;
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge mclk_in);
    for (int i = 0; i < n; i++) begin
      bits[i] = line_in;
      repeat (BIT_CLKS) @(posedge mclk_in);
    end
  endtask : catch
endmodule : scx_remote
`default_nettype wire

//--- tb/tb_scx_serial.sv
// Testbench of the serial character transmitter and receiver
`timescale 1ns/1ps
`default_nettype none
module tb_scx_serial;
  import scx_pkg::*;
  localparam int BITC = 32;
  logic mclk_in = 0, reset_in = 1, en = 0, te = 0, m9 = 0, inv = 0, brk = 0, lext = 0;
  logic st1 = 0, dr = 0, wv = 0, t8 = 0, nf;
  logic [7:0] wd = 8'h00, rdat;
  logic rdy, txd, oen, own, rxd, r8, tempty, tdone, rfull, fe, break_flag, tirq, rirq;
  int num_errors = 0, n_tests = 0;
  scx_serial #(.RT_DIV(2), .FIFO_DEPTH(16)) u_scx_serial (.mclk_in(mclk_in), .reset_in(reset_in),
    .serial_unit_enable_in(en), .tx_enable_in(te), .nine_bit_select_in(m9), .tx_invert_in(inv),
    .send_break_in(brk), .break_len_ext_in(lext), .tx_ninth_bit_in(t8), .tx_empty_irq_en_in(1'b1),
    .tx_done_irq_en_in(1'b1), .rx_full_irq_en_in(1'b1), .tx_data_in(wd), .tx_data_valid_in(wv),
    .tx_data_ready_out(rdy), .stat_one_read_in(st1), .data_read_in(dr), .rxd_in(rxd), .txd_out(txd),
    .txd_oe_n_out(oen), .pins_owned_out(own), .rx_data_out(rdat), .rx_ninth_bit_out(r8),
    .tx_empty_flag_out(tempty), .tx_done_flag_out(tdone), .rx_full_flag_out(rfull),
    .framing_flag_out(fe), .noise_flag_out(nf), .overrun_flag_out(), .break_flag_out(break_flag),
    .rx_active_flag_out(), .tx_irq_out(tirq), .rx_irq_out(rirq));
  scx_remote #(.BIT_CLKS(BITC)) u_scx_remote (.mclk_in(mclk_in), .line_in(txd), .line_out(rxd));
  // Clock, 8 ns period
  initial forever #4 mclk_in = ~mclk_in;
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // Preamble, then framed byte, then idle and flags
  task automatic t_tx;
    logic [10:0] f;
    @(posedge mclk_in) en <= 1;
    @(posedge mclk_in) te <= 1;
    st1 <= 1;
    @(posedge mclk_in) st1 <= 0;
    wd <= 8'hA5;
    wv <= 1;
    @(posedge mclk_in) wv <= 0;
    repeat (3) @(posedge mclk_in);
    chk({own, oen, tempty}, 3'b100);
    repeat (9 * BITC) @(posedge mclk_in);
    chk(txd, 1);
    u_scx_remote.catch(f, 10);
    chk(f[9:0], {1'b1, 8'hA5, 1'b0});
    repeat (2 * BITC) @(posedge mclk_in);
    chk({txd, tdone, tempty, tirq}, 4'hF);
  endtask : t_tx
  // Back-to-back breaks, then a mark bit
  task automatic t_brk;
    logic [10:0] f;
    @(posedge mclk_in) brk <= 1;
    u_scx_remote.catch(f, 11);
    chk(f, 11'h000);
    brk <= 0;
    wd  <= 8'h96;
    wv  <= 1;
    @(posedge mclk_in) wv <= 0;
    u_scx_remote.catch(f, 10);
    chk(f[9:0], {1'b1, 8'h96, 1'b0});
    repeat (2 * BITC) @(posedge mclk_in);
    chk(txd, 1);
  endtask : t_brk
  // Receive one frame, check data and flags, then clear
  task automatic t_rx(input logic m, input logic [10:0] f, input int n, input logic [11:0] exp);
    @(posedge mclk_in) m9 <= m;
    u_scx_remote.send(f, n);
    for (int i = 0; i < 4 * BITC && rfull !== 1'b1; i++) @(posedge mclk_in);
    repeat (2) @(posedge mclk_in);
    chk({rdat, r8, fe, break_flag, rirq, nf}, {exp, 1'b0});
    st1 <= 1;
    @(posedge mclk_in) st1 <= 0;
    dr <= 1;
    @(posedge mclk_in) dr <= 0;
    repeat (2) @(posedge mclk_in);
    chk(rfull, 0);
  endtask : t_rx
  // Fill the queue with the transmitter off, then drain
  task automatic t_fill;
    int k;
    k = 0;
    @(posedge mclk_in) te <= 0;
    repeat (12 * BITC) @(posedge mclk_in);
    wv <= 1;
    for (int i = 0; i < 20; i++) begin
      @(posedge mclk_in);
      k += int'(rdy);
    end
    wv <= 0;
    te <= 1;
    chk(k, 17);
    for (int i = 0; i < 9000 && tdone !== 1'b1; i++) @(posedge mclk_in);
    chk({tdone, txd}, 2'b11);
  endtask : t_fill
  // Nine-bit frames with an idle character queued between them
  task automatic t_tx9;
    logic [10:0] f;
    @(posedge mclk_in) m9 <= 1;
    t8 <= 1;
    wd <= 8'h5A;
    wv <= 1;
    @(posedge mclk_in) wv <= 0;
    repeat (4 * BITC) @(posedge mclk_in);
    te <= 0;
    @(posedge mclk_in) te <= 1;
    wd <= 8'hC3;
    wv <= 1;
    @(posedge mclk_in) wv <= 0;
    repeat (12 * BITC) @(posedge mclk_in);
    chk(txd, 1);
    u_scx_remote.catch(f, 11);
    chk(f, {2'b11, 8'hC3, 1'b0});
    m9 <= 0;
  endtask : t_tx9
  // Inverted idle, then pins released
  task automatic t_inv;
    @(posedge mclk_in) inv <= 1;
    repeat (2) @(posedge mclk_in);
    chk(txd, 0);
    en <= 0;
    repeat (2) @(posedge mclk_in);
    chk({own, oen}, 2'b01);
  endtask : t_inv
  // Watchdog
  initial begin
    repeat (40000) @(posedge mclk_in);
    num_errors++;
    give_verdict();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge mclk_in);
    reset_in <= 0;
    @(posedge mclk_in);
    chk({txd, oen, own, tempty, tdone, rfull}, 6'b110110);
    t_tx();
    t_brk();
    t_rx(0, {2'b11, 8'h3C, 1'b0}, 10, {8'h3C, 4'b0001});
    t_rx(1, {1'b1, 9'h1C5, 1'b0}, 11, {8'hC5, 4'b1001});
    t_rx(0, 11'h000, 11, {8'h00, 4'b0111});
    @(posedge mclk_in) lext <= 1;
    t_rx(0, 11'h400, 11, {8'h00, 4'b0101});
    t_rx(0, 11'h000, 12, {8'h00, 4'b0111});
    t_fill();
    t_tx9();
    t_inv();
    give_verdict();
  end
endmodule : tb_scx_serial
`default_nettype wire
